// ---- logic/byte_fifo.sv ----
`timescale 1ns/100ps
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,     // system clock
  input  wire logic         rst_i,     // sync reset
  input  wire logic         flush_i,   // drop all contents
  input  wire logic         in_valid_i, // write request
  output logic              in_ready_o, // room left
  input  wire logic [W-1:0] in_data_i,  // write data
  output logic              out_valid_o, // data waiting
  input  wire logic         out_ready_i, // reader takes word
  output logic [W-1:0]      out_data_o   // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready_o  = count != (AW+1)'(DEPTH);
  assign out_valid_o = count != '0;
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage write, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

// ---- logic/flash_defines.svh ----
`ifndef FLASH_DEFINES_SVH
`define FLASH_DEFINES_SVH
// opcodes
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_PAGE_PROGRAM   8'h02
`define OP_QUAD_PAGE_PROG 8'h38
`define OP_CONT_PROGRAM   8'had
`define OP_DEEP_PWR_DOWN  8'hb9
`define OP_SIGNATURE      8'hab
`define OP_ID_READ_A      8'h90
`define OP_ID_READ_B      8'hef
`define OP_ID_READ_C      8'hdf
`define OP_RB_ENABLE      8'h70
`define OP_RB_DISABLE     8'h80
// identification codes, values arbitrary
`define ID_MAKER          8'h5a
`define ID_DEVICE         8'h35
`define ID_SIGNATURE      8'h35
`define ID_DEV_FIRST_ADDR 8'h01
// timing, clock period and times in ns
`define CLK_PERIOD_NS     10
`define PAGE_PROG_NS      1400000
`define BYTE_PROG_NS      9000
`define PD_ENTRY_NS       10000
`define PD_RELEASE_NS     8800
// pin positions and field sizes
`define SI_LINE           0
`define SO_LINE           1
`define BLOCK_SHIFT       16
`endif

// ---- logic/flash_pkg.sv ----
package flash_pkg;
  typedef enum logic [2:0] {S_CMD, S_ONE, S_ADDR, S_DATA, S_ID, S_SKIP} phase_t;
  typedef enum logic [1:0] {T_NONE, T_PROG, T_PD_IN, T_PD_OUT} timer_t;
endpackage : flash_pkg

// ---- logic/flash_prog_power_id.sv ----
// How it works
// - select must rise exactly on a data byte boundary or command is dropped
// - valid page program sets busy for its cycle, then clears busy and write latch
// - page program into a protected block is not executed
// - quad page program needs write latch and quad enable; uses four lines
// - continuous program needs write latch; two bytes go to even then odd address
// - one data byte programs nothing; bytes past the second are dropped
// - continuous program into protected area is ignored, write latch kept
// - address steps per pair, no wrap; at last free address mode ends
// - in continuous mode only continuous and write disable opcodes pass
// - with ready/busy enabled in continuous mode, ready/busy on serial out while select low; released when select high
// - ready/busy enable and disable refused during continuous mode
// - deep power-down ignores all but release and signature read
// - power-down entered only after entry delay following select rise
// - release needs select to rise right after eighth opcode bit, or after one full signature byte has been read
// - release is immediate if awake, else takes the release delay
// - signature byte repeats while clocked; release allowed after one full byte read
// - release and signature read refused while a write cycle runs
// - id read: two dummies, address; maker and device alternate, 01 swaps
// - quad enable gates every four-line operation
`timescale 1ns/100ps
`include "flash_defines.svh"
module flash_prog_power_id #(
  parameter int ADDR_W     = 22,
  parameter int FIFO_DEPTH = 16,
  parameter int PP_CYCLES  = (`PAGE_PROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int BP_CYCLES  = (`BYTE_PROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int PDI_CYCLES = (`PD_ENTRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int PDO_CYCLES = `PD_RELEASE_NS / `CLK_PERIOD_NS
) (
  input  wire logic              CLK_I,            // system clock
  input  wire logic              RST_I,            // sync reset
  input  wire logic              CS_N_I,           // chip select pin
  input  wire logic              SCLK_I,           // serial clock pin
  input  wire logic [3:0]        SIO_I,            // quad_data_lines in
  output logic [3:0]             SIO_O,            // quad_data_lines out
  output logic [3:0]             SIO_OE_O,         // line drive enables
  input  wire logic              QUAD_ENABLE_I,    // quad_enable_bit
  input  wire logic [3:0]        BLOCK_PROTECT_I,  // block_protect_bits
  input  wire logic              EXT_BUSY_I,       // erase or status write running
  output logic                   BUSY_FLAG_O,      // busy_flag
  output logic                   WRITE_ENABLE_LATCH_O, // write_enable_latch
  output logic                   CP_MODE_O,        // continuous_program mode bit
  output logic                   POWER_DOWN_O,     // deep power-down state
  output logic                   RB_ENABLE_O,      // ready_busy_output_enable state
  output logic                   PROG_VALID_O,     // byte to array
  input  wire logic              PROG_READY_I,     // array takes byte
  output logic [ADDR_W-1:0]      PROG_ADDR_O,      // array address
  output logic [7:0]             PROG_DATA_O       // array data
);
  import flash_pkg::*;

  logic cs_m, cs_s, cs_d, sclk_m, sclk_s, sclk_d;
  logic [3:0] sio_m, sio_s;
  phase_t phase;
  timer_t tk;
  logic [7:0] op, sh, next_byte;
  logic [2:0] bits, next_bits, out_bit;
  logic [1:0] nbyte, tot, data_cnt;
  logic [23:0] addr;
  logic [ADDR_W-1:0] cp_addr, prog_addr;
  logic [31:0] tcnt;
  logic quad, rej, sel, full_read, so_q, so_oe;
  logic write_enable_latch, cp_mode, pd, rb_en;
  logic cs_rise, sclk_rise, sclk_fall, byte_done, busy, busy_any;
  logic is_pp, pp_ok, cp_ok, pp_go, one, rel_ok, id_enter, rb_drive, t_done;
  logic fifo_in_ready, fifo_out_valid, drain;
  logic [7:0] id_byte;

  // true when address lies in the block-protected top region
  function automatic logic prot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W:0] size;
    size = '0;
    if (BLOCK_PROTECT_I == 4'h0) return 1'b0;
    if (32'(BLOCK_PROTECT_I) > 32'(ADDR_W - `BLOCK_SHIFT)) return 1'b1;
    size = (ADDR_W+1)'(1) << (`BLOCK_SHIFT - 1 + 32'(BLOCK_PROTECT_I));
    return {1'b0, ~a} < size;
  endfunction : prot

  // opcode filter, decides the phase after the first byte
  function automatic phase_t decode(input logic [7:0] b);
    if (busy_any || (pd && b != `OP_SIGNATURE)) return S_SKIP;
    if (cp_mode && b != `OP_CONT_PROGRAM && b != `OP_WRITE_DISABLE) return S_SKIP;
    unique case (b)
      `OP_PAGE_PROGRAM:   return write_enable_latch ? S_ADDR : S_SKIP;
      `OP_QUAD_PAGE_PROG: return (write_enable_latch && QUAD_ENABLE_I) ? S_ADDR : S_SKIP;
      `OP_CONT_PROGRAM:   return !write_enable_latch ? S_SKIP : (cp_mode ? S_DATA : S_ADDR);
      `OP_SIGNATURE, `OP_ID_READ_A, `OP_ID_READ_B, `OP_ID_READ_C: return S_ADDR;
      `OP_WRITE_ENABLE, `OP_WRITE_DISABLE, `OP_DEEP_PWR_DOWN: return S_ONE;
      `OP_RB_ENABLE, `OP_RB_DISABLE: return cp_mode ? S_SKIP : S_ONE;
      default:            return S_SKIP;
    endcase
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops before any use
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      {cs_m, cs_s, cs_d} <= 3'h7;
      {sclk_m, sclk_s, sclk_d} <= 3'h0;
      sio_m <= 4'h0;
      sio_s <= 4'h0;
    end else begin
      cs_m   <= CS_N_I;
      cs_s   <= cs_m;
      cs_d   <= cs_s;
      sclk_m <= SCLK_I;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      sio_m  <= SIO_I;
      sio_s  <= sio_m;
    end
  end

  assign cs_rise   = cs_s & ~cs_d;
  assign sclk_rise = sclk_s & ~sclk_d & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_s;
  // quad frames take a nibble per edge, single frames one bit on the input line
  assign next_byte = quad ? {sh[3:0], sio_s} : {sh[6:0], sio_s[`SI_LINE]};
  assign next_bits = bits + (quad ? 3'h4 : 3'h1);
  assign byte_done = sclk_rise && next_bits == 3'h0;
  assign busy      = tk == T_PROG;
  assign busy_any  = busy | EXT_BUSY_I;
  assign id_enter  = byte_done && phase == S_ADDR && nbyte == 2'h2 && !is_pp
                     && op != `OP_CONT_PROGRAM;

  ////////////////////////////////////////////////////////////////////////////////
  // command frame: opcode, address, data bytes; phase and counts cleared whenever select is high, opcode and address kept until reset
  always_ff @(posedge CLK_I) begin
    if (RST_I || cs_s) begin
      phase    <= S_CMD;
      bits     <= 3'h0;
      quad     <= 1'b0;
      tot      <= 2'h0;
      nbyte    <= 2'h0;
      data_cnt <= 2'h0;
      rej      <= 1'b0;
      if (RST_I) begin
        op   <= 8'h00;
        sh   <= 8'h00;
        addr <= 24'h0;
      end
    end else if (sclk_rise) begin
      sh   <= next_byte;
      bits <= next_bits;
      if (byte_done) begin
        if (tot != 2'h3) tot <= tot + 2'h1;
        unique case (phase)
          S_CMD: begin
            op    <= next_byte;
            phase <= decode(next_byte);
            rej   <= decode(next_byte) == S_SKIP;
            quad  <= next_byte == `OP_QUAD_PAGE_PROG && decode(next_byte) == S_ADDR;
          end
          S_ADDR: begin
            addr  <= {addr[15:0], next_byte};
            nbyte <= nbyte + 2'h1;
            if (nbyte == 2'h2) phase <= id_enter ? S_ID : S_DATA;
          end
          S_DATA: if (data_cnt != 2'h3) data_cnt <= data_cnt + 2'h1;
          S_ONE, S_ID, S_SKIP: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // acceptance at select rise
  assign is_pp  = op == `OP_PAGE_PROGRAM || op == `OP_QUAD_PAGE_PROG;
  assign pp_ok  = is_pp && phase == S_DATA && bits == 3'h0 && data_cnt != 2'h0
                  && !prot(addr[ADDR_W-1:0]);
  assign cp_ok  = op == `OP_CONT_PROGRAM && phase == S_DATA && bits == 3'h0
                  && data_cnt >= 2'h2 && (cp_mode || !prot(addr[ADDR_W-1:0]));
  assign pp_go  = cs_rise && (pp_ok || cp_ok);
  assign one    = cs_rise && phase == S_ONE && tot == 2'h1 && bits == 3'h0;
  // release: exactly eight bits, or a signature read with one full byte out
  assign rel_ok = cs_rise && op == `OP_SIGNATURE && !rej && bits == 3'h0
                  && ((phase == S_ADDR && tot == 2'h1) || (phase == S_ID && full_read));
  assign t_done = tk != T_NONE && tcnt == 32'h0 && (tk != T_PROG || !fifo_out_valid);

  ////////////////////////////////////////////////////////////////////////////////
  // mode state, self-timed cycles and latches
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      tk      <= T_NONE;
      tcnt    <= 32'h0;
      write_enable_latch     <= 1'b0;
      cp_mode <= 1'b0;
      pd      <= 1'b0;
      rb_en   <= 1'b0;
      cp_addr <= '0;
    end else begin
      if (tcnt != 32'h0) tcnt <= tcnt - 32'h1;
      if (t_done) begin
        tk <= T_NONE;
        unique case (tk)
          T_PROG: begin
            if (!cp_mode) begin
              write_enable_latch <= 1'b0;
            end else begin
              cp_addr <= cp_addr + ADDR_W'(2);
              // no wrap: top of memory or next protected pair ends the mode
              if (&cp_addr[ADDR_W-1:1] || prot(cp_addr + ADDR_W'(2))) begin
                cp_mode <= 1'b0;
                write_enable_latch     <= 1'b0;
              end
            end
          end
          T_PD_IN:  pd <= 1'b1;
          T_PD_OUT: pd <= 1'b0;
          T_NONE: ;
        endcase
      end
      if (pp_go) begin
        tk   <= T_PROG;
        tcnt <= cp_ok ? BP_CYCLES : PP_CYCLES;
        if (cp_ok && !cp_mode) begin
          cp_mode <= 1'b1;
          cp_addr <= {addr[ADDR_W-1:1], 1'b0};
        end
      end
      if (one && op == `OP_DEEP_PWR_DOWN) begin
        tk   <= T_PD_IN;
        tcnt <= PDI_CYCLES;
      end
      if (rel_ok && pd) begin
        tk   <= T_PD_OUT;
        tcnt <= PDO_CYCLES;
      end
      if (one && op == `OP_WRITE_ENABLE) write_enable_latch <= 1'b1;
      if (one && op == `OP_WRITE_DISABLE) begin
        write_enable_latch     <= 1'b0;
        cp_mode <= 1'b0;
      end
      if (one && op == `OP_RB_ENABLE)  rb_en <= 1'b1;
      if (one && op == `OP_RB_DISABLE) rb_en <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // program path: bytes buffered while received, drained only in the cycle.
  // bytes past the buffer depth are dropped, so a page keeps its first bytes.
  assign drain        = busy;
  assign PROG_VALID_O = fifo_out_valid & drain;

  byte_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .flush_i     (cs_rise && !pp_go),
    .in_valid_i  (byte_done && phase == S_DATA && (!(op == `OP_CONT_PROGRAM) || data_cnt < 2'h2)),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (next_byte),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (PROG_READY_I & drain),
    .out_data_o  (PROG_DATA_O)
  );

  // address follows the buffer head, wrapping inside the page
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      prog_addr <= '0;
    end else if (pp_go) begin
      prog_addr <= cp_ok ? (cp_mode ? cp_addr : {addr[ADDR_W-1:1], 1'b0}) : addr[ADDR_W-1:0];
    end else if (PROG_VALID_O && PROG_READY_I) begin
      prog_addr <= {prog_addr[ADDR_W-1:8], prog_addr[7:0] + 8'h01};
    end
  end
  assign PROG_ADDR_O = prog_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // id output: signature repeats, maker and device alternate
  assign id_byte  = op == `OP_SIGNATURE ? `ID_SIGNATURE : (sel ? `ID_DEVICE : `ID_MAKER);
  assign rb_drive = cp_mode && rb_en && !cs_s;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      out_bit   <= 3'h0;
      sel       <= 1'b0;
      full_read <= 1'b0;
    end else if (id_enter) begin
      out_bit   <= 3'h0;
      sel       <= next_byte == `ID_DEV_FIRST_ADDR && op != `OP_SIGNATURE;
      full_read <= 1'b0;
    end else if (phase == S_ID && sclk_fall) begin
      out_bit <= out_bit + 3'h1;
      if (out_bit == 3'h7) begin
        full_read <= 1'b1;
        if (op != `OP_SIGNATURE) sel <= ~sel;
      end
    end
  end

  // serial output: id bits on falling clock, else ready/busy level
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      so_q  <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so_oe <= !cs_s && (phase == S_ID || rb_drive);
      if (phase == S_ID && sclk_fall) so_q <= id_byte[~out_bit];
      else if (rb_drive) so_q <= ~busy;
    end
  end

  assign SIO_O    = {2'b00, so_q, 1'b0};
  assign SIO_OE_O = {2'b00, so_oe, 1'b0};
  assign BUSY_FLAG_O          = busy;
  assign WRITE_ENABLE_LATCH_O = write_enable_latch;
  assign CP_MODE_O            = cp_mode;
  assign POWER_DOWN_O         = pd;
  assign RB_ENABLE_O          = rb_en;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  property p_busy_on;
    pp_go |=> BUSY_FLAG_O [*2];
  endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy not set after program");

  property p_wel_clr;
    $fell(BUSY_FLAG_O) && !$past(cp_mode) |-> !WRITE_ENABLE_LATCH_O;
  endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("write latch kept after program");

  property p_partial;
    cs_rise && is_pp && phase == S_DATA && bits != 3'h0 |=> !BUSY_FLAG_O;
  endproperty
  a_partial: assert property (p_partial) else $error("partial byte accepted");

  property p_protect;
    cs_rise && is_pp && prot(addr[ADDR_W-1:0]) && !busy |=> !BUSY_FLAG_O;
  endproperty
  a_protect: assert property (p_protect) else $error("protected page programmed");

  property p_quad_gate;
    byte_done && phase == S_CMD && next_byte == `OP_QUAD_PAGE_PROG && !QUAD_ENABLE_I
      |=> phase == S_SKIP;
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("quad program without enable");

  property p_cp_one;
    cs_rise && op == `OP_CONT_PROGRAM && data_cnt == 2'h1 && !busy |=> !BUSY_FLAG_O;
  endproperty
  a_cp_one: assert property (p_cp_one) else $error("single byte programmed");

  property p_cp_prot;
    cs_rise && !cp_mode && op == `OP_CONT_PROGRAM && prot(addr[ADDR_W-1:0]) && !busy
      |=> $stable(WRITE_ENABLE_LATCH_O) && !CP_MODE_O;
  endproperty
  a_cp_prot: assert property (p_cp_prot) else $error("protected entry changed state");

  property p_rb_release;
    cs_s && cs_d |=> !SIO_OE_O[`SO_LINE];
  endproperty
  a_rb_release: assert property (p_rb_release) else $error("output driven while deselected");

  property p_pd_ignore;
    POWER_DOWN_O && byte_done && phase == S_CMD && next_byte != `OP_SIGNATURE |=> phase == S_SKIP;
  endproperty
  a_pd_ignore: assert property (p_pd_ignore) else $error("command taken in power-down");

  property p_pd_entry;
    one && op == `OP_DEEP_PWR_DOWN && !pd |=> !POWER_DOWN_O [*8];
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down entered early");

  property p_res_busy;
    byte_done && phase == S_CMD && busy_any |=> phase == S_SKIP;
  endproperty
  a_res_busy: assert property (p_res_busy) else $error("command taken while busy");

  c_pp: cover property (pp_go && !cp_ok);
  c_cp: cover property (pp_go && cp_ok && cp_mode);
  c_pd: cover property ($fell(POWER_DOWN_O));
  c_id: cover property (phase == S_ID && full_read && sel);
  c_full: cover property (!fifo_in_ready && phase == S_DATA);
endmodule : flash_prog_power_id

// ---- tb/flash_host.sv ----
`timescale 1ns/100ps
module flash_host (
  input  wire logic       clk_i,  // system clock
  input  wire logic       so_i,   // serial out wire level
  output logic            cs_n_o, // chip select, low active
  output logic            sclk_o, // serial clock, parked low
  output logic [3:0]      sio_o   // data lines to device
);
  // idle: deselected, clock still between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sio_o  = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // moves land just after a clock edge so sampling never races
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // 160 ns serial clock keeps quad transfers well under 20 MHz
  task automatic bit_io(input logic [3:0] v, output logic s);
    sio_o = v;
    tick(8);
    sclk_o = 1'b1;
    s = so_i;
    tick(8);
    sclk_o = 1'b0;
  endtask : bit_io
  // msb first; quad sends high nibble then low nibble
  task automatic xfer(input logic [7:0] b, input logic quad, input int nb,
                      output logic [7:0] r);
    logic s;
    r = 8'h00;
    if (quad) begin
      bit_io(b[7:4], s);
      bit_io(b[3:0], s);
    end else begin
      // unused lines toggle so they never look like a held value
      for (int i = 7; i > 7 - nb; i--) begin
        bit_io({~sio_o[3:1], b[i]}, s);
        r = {r[6:0], s};
      end
    end
  endtask : xfer
  // select low with a short setup before the first clock
  task automatic begin_frame();
    cs_n_o = 1'b0;
    tick(4);
  endtask : begin_frame
  // released lines flip; select stays high past the minimum gap
  task automatic end_frame();
    tick(2);
    cs_n_o = 1'b1;
    sio_o  = ~sio_o;
    tick(8);
  endtask : end_frame
endmodule : flash_host

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`include "flash_defines.svh"
module tb_top;
  logic        clk, rst, cs_n, sclk, qe, ext_busy, pready, stall;
  logic        busy, write_enable_latch, cp, pd, rbe, pvalid;
  logic [3:0]  sio, sio_in, sio_out, sio_oe, bp;
  logic [21:0] paddr;
  logic [7:0]  pdata, r;
  logic [15:0] rd;
  logic [21:0] qa[$];
  logic [7:0]  qd[$];
  int          mismatches = 0;
  int          total_checks = 0;
  // wire level: device drives only where its enable is high
  assign sio_in = {sio[3:2], sio_oe[1] ? sio_out[1] : sio[1], sio[0]};
  flash_host host (.clk_i(clk), .so_i(sio_in[1]), .cs_n_o(cs_n), .sclk_o(sclk), .sio_o(sio));
  flash_prog_power_id #(.PP_CYCLES(200), .BP_CYCLES(50), .PDI_CYCLES(20), .PDO_CYCLES(20)) uut (
    .CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCLK_I(sclk), .SIO_I(sio_in), .SIO_O(sio_out),
    .SIO_OE_O(sio_oe), .QUAD_ENABLE_I(qe), .BLOCK_PROTECT_I(bp), .EXT_BUSY_I(ext_busy),
    .BUSY_FLAG_O(busy), .WRITE_ENABLE_LATCH_O(write_enable_latch), .CP_MODE_O(cp), .POWER_DOWN_O(pd),
    .RB_ENABLE_O(rbe), .PROG_VALID_O(pvalid), .PROG_READY_I(pready), .PROG_ADDR_O(paddr),
    .PROG_DATA_O(pdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // array side takes a byte every other cycle, so the buffer sees back-pressure
  always @(posedge clk) pready <= #1 !rst && !stall && !pready;
  // array side: log every accepted byte
  always @(posedge clk) begin
    if (rst === 1'b0 && pvalid === 1'b1 && pready === 1'b1) begin
      qa.push_back(paddr);
      qd.push_back(pdata);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk_flag(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %b seen %b", n, e, g);
    end
  endtask : chk_flag
  task automatic chk_val(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk_val
  // n whole bytes from the top of v, then xb stray bits; rd keeps last two reads
  task automatic cmd(input logic [63:0] v, input int n, input int xb, input logic quad);
    host.begin_frame();
    for (int i = 0; i < n; i++) begin
      host.xfer(v[63-8*i -: 8], quad && i > 0, 8, r);
      rd = {rd[7:0], r};
    end
    if (xb > 0) host.xfer(v[63-8*n -: 8], 1'b0, xb, r);
    host.end_frame();
  endtask : cmd
  task automatic prog(input logic [21:0] a, input logic [7:0] d);
    if (qa.size() == 0) chk_val("prog count", 24'h1, 24'h0);
    else begin
      chk_val("prog addr", {2'h0, a}, {2'h0, qa.pop_front()});
      chk_val("prog data", {16'h0, d}, {16'h0, qd.pop_front()});
    end
  endtask : prog
  // bounded poll of the busy flag before the next command
  task automatic wait_idle();
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) host.tick(1);
    chk_flag("busy", 1'b0, busy);
  endtask : wait_idle
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, qe, bp, ext_busy, stall, rd} = {1'b1, 1'b0, 4'h0, 1'b0, 1'b0, 16'h0};
    host.tick(2);
    rst = 1'b0;
    host.tick(4);
    chk_val("flags", 24'h0, {busy, write_enable_latch, cp, pd, rbe, sio_oe});
    cmd({`OP_WRITE_ENABLE, 56'h0}, 1, 0, 0);
    chk_flag("wel", 1'b1, write_enable_latch);
    cmd({`OP_PAGE_PROGRAM, 24'h000010, 16'ha53c, 16'h0}, 6, 0, 0);
    chk_flag("busy", 1'b1, busy);
    wait_idle();
    chk_flag("wel", 1'b0, write_enable_latch);
    prog(22'h10, 8'ha5);
    prog(22'h11, 8'h3c);
    cmd({`OP_WRITE_ENABLE, 56'h0}, 1, 0, 0);
    cmd({`OP_PAGE_PROGRAM, 24'h000010, 8'ha5, 24'h0}, 5, 4, 0);
    chk_flag("busy", 1'b0, busy);
    bp = 4'h7;
    cmd({`OP_PAGE_PROGRAM, 24'h000010, 8'ha5, 24'h0}, 5, 0, 0);
    chk_flag("busy", 1'b0, busy);
    cmd({`OP_CONT_PROGRAM, 24'h000020, 16'h1122, 16'h0}, 6, 0, 0);
    chk_val("cp wel", 24'h1, {cp, write_enable_latch});
    bp = 4'h0;
    cmd({`OP_QUAD_PAGE_PROG, 24'h000040, 8'hc3, 24'h0}, 5, 0, 1);
    chk_flag("busy", 1'b0, busy);
    qe = 1'b1;
    cmd({`OP_QUAD_PAGE_PROG, 24'h000040, 8'hc3, 24'h0}, 5, 0, 1);
    wait_idle();
    prog(22'h40, 8'hc3);
    cmd({`OP_RB_ENABLE, 56'h0}, 1, 0, 0);
    cmd({`OP_WRITE_ENABLE, 56'h0}, 1, 0, 0);
    cmd({`OP_CONT_PROGRAM, 24'h000020, 24'h112233, 8'h0}, 7, 0, 0);
    chk_val("rb cp", 24'h3, {rbe, cp});
    wait_idle();
    prog(22'h20, 8'h11);
    prog(22'h21, 8'h22);
    // inside the mode a pair needs no address: it lands on the next pair
    cmd({`OP_CONT_PROGRAM, 16'h4455, 40'h0}, 3, 0, 0);
    wait_idle();
    prog(22'h22, 8'h44);
    prog(22'h23, 8'h55);
    host.begin_frame();
    host.tick(4);
    chk_val("ready on so", 24'h3, {sio_oe[1], sio_out[1]});
    host.xfer(`OP_RB_DISABLE, 1'b0, 8, r);
    host.end_frame();
    chk_val("oe rb", 24'h1, {sio_oe[1], rbe});
    cmd({`OP_WRITE_DISABLE, 56'h0}, 1, 0, 0);
    chk_val("cp wel", 24'h0, {cp, write_enable_latch});
    // a pair at the top of memory ends the mode, no wrap to address zero
    cmd({`OP_WRITE_ENABLE, 56'h0}, 1, 0, 0);
    cmd({`OP_CONT_PROGRAM, 24'h3ffffe, 16'h6677, 16'h0}, 6, 0, 0);
    wait_idle();
    prog(22'h3ffffe, 8'h66);
    prog(22'h3fffff, 8'h77);
    chk_val("cp end", 24'h0, {cp, write_enable_latch});
    cmd({`OP_WRITE_ENABLE, 56'h0}, 1, 0, 0);
    cmd({`OP_DEEP_PWR_DOWN, 56'h0}, 1, 0, 0);
    chk_flag("pd early", 1'b0, pd);
    host.tick(20);
    chk_flag("pd", 1'b1, pd);
    cmd({`OP_WRITE_DISABLE, 56'h0}, 1, 0, 0);
    chk_flag("wel", 1'b1, write_enable_latch);
    ext_busy = 1'b1;
    cmd({`OP_SIGNATURE, 56'h0}, 1, 0, 0);
    host.tick(24);
    chk_flag("pd", 1'b1, pd);
    ext_busy = 1'b0;
    cmd({`OP_SIGNATURE, 56'h0}, 1, 0, 0);
    chk_flag("pd hold", 1'b1, pd);
    host.tick(20);
    chk_flag("pd", 1'b0, pd);
    cmd({`OP_ID_READ_A, 24'h0, 32'h0}, 6, 0, 0);
    chk_val("id", {8'h0, `ID_MAKER, `ID_DEVICE}, {8'h0, rd});
    cmd({`OP_ID_READ_C, 16'h0, `ID_DEV_FIRST_ADDR, 32'h0}, 6, 0, 0);
    chk_val("id swap", {8'h0, `ID_DEVICE, `ID_MAKER}, {8'h0, rd});
    cmd({`OP_SIGNATURE, 56'h0}, 6, 0, 0);
    chk_val("signature", {8'h0, `ID_SIGNATURE, `ID_SIGNATURE}, {8'h0, rd});
    // stalled array: fifo keeps 16 of 17 bytes
    stall = 1'b1;
    host.begin_frame();
    for (int i = 0; i < 21; i++) host.xfer(i < 4 ? {6'h0, i == 0, i == 2} : 8'(i - 4), 1'b0, 8, r);
    host.end_frame();
    host.tick(300);
    chk_val("stalled", 24'h3, {qa.size() == 0, busy});
    stall = 1'b0;
    wait_idle();
    for (int i = 0; i < 16; i++) prog(22'h100 + 22'(i), 8'(i));
    chk_val("extra prog", 24'h0, 24'(qa.size()));
    results();
  end
endmodule : tb_top
